// *** bench/testbench.sv ***
// Self-checking bench for mie_core: random and directed operations.
// Assumes the fetch handshake and reset sequence of the core's contract.
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   mie_pkg::mie_op_t instr_op = mie_pkg::MIE_OP_NOP;
   logic [5:0] instr_addr = 6'h00;
   logic instr_dest = 1'b0;
   logic [7:0] instr_imm = 8'h00;
   logic instr_ready, zero_flag, retired, discarded, bad_operand;
   logic [7:0] working_register, port_dir_a, port_dir_b, port_dir_c;
   logic [10:0] pc, stack_top;
   int n_errors = 0;
   int n_checks = 0;
   logic [7:0] m_file [64];
   logic [7:0] m_work, m_dir [3];
   logic [10:0] m_pc, m_stack;
   logic m_zero, m_skip;

   always #2.5 sys_clk = ~sys_clk;

   mie_core #(.PIN28(1'b1), .STACK_DEPTH(4)) i_mie_core (
      .sys_clk(sys_clk), .resetn(resetn), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_addr(instr_addr),
      .instr_dest(instr_dest), .instr_imm(instr_imm),
      .instr_ready(instr_ready), .working_register(working_register),
      .zero_flag(zero_flag), .pc(pc), .stack_top(stack_top),
      .port_dir_a(port_dir_a), .port_dir_b(port_dir_b),
      .port_dir_c(port_dir_c), .retired(retired),
      .discarded(discarded), .bad_operand(bad_operand)
   );

   // ------------------------------------------------------------
   // Compare and closing tasks
   // ------------------------------------------------------------
   function automatic logic f_zero(input logic [7:0] r);
      return r == 8'h00;
   endfunction

   task automatic fail(input string what);
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                       input string what);
      n_checks++;
      if (g !== e) fail(what);
   endtask

   task automatic chk11(input logic [10:0] g, input logic [10:0] e,
                        input string what);
      n_checks++;
      if (g !== e) fail(what);
   endtask

   task automatic chk1(input logic g, input logic e, input string what);
      n_checks++;
      if (g !== e) fail(what);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // One operation: present, wait for take, model, compare
   // ------------------------------------------------------------
   task automatic do_op(input mie_pkg::mie_op_t op, input logic [5:0] a,
                        input logic d, input logic [7:0] im);
      int k;
      logic [7:0] r;
      logic disc, trap, bad;
      instr_valid = 1'b1;
      instr_op = op;
      instr_addr = a;
      instr_dest = d;
      instr_imm = im;
      k = 0;
      while (instr_ready !== 1'b1 && k < 20) begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 20) fail("ready wait");
      @(negedge sys_clk);
      disc = m_skip;
      m_skip = 1'b0;
      trap = 1'b0;
      bad = 1'b0;
      m_pc = m_pc + 11'h001;
      if (!disc) begin
         case (op)
            mie_pkg::MIE_OP_INC_SKIP_ZERO: begin
               r = m_file[a] + 8'h01;
               if (d) m_file[a] = r;
               else m_work = r;
               m_skip = f_zero(r);
            end
            mie_pkg::MIE_OP_SOFT_TRAP: begin
               m_stack = m_pc;
               m_pc = mie_pkg::MIE_TRAP_VECTOR;
               trap = 1'b1;
            end
            mie_pkg::MIE_OP_OR_WORK_WITH_FILE: begin
               r = m_work | m_file[a];
               m_zero = f_zero(r);
               if (d) m_file[a] = r;
               else m_work = r;
            end
            mie_pkg::MIE_OP_OR_IMM_INTO_WORK: begin
               m_work = m_work | im;
               m_zero = f_zero(m_work);
            end
            mie_pkg::MIE_OP_PORT_DIRECTION_LOAD: begin
               if (a >= 6'h05 && a <= 6'h07) m_dir[a - 6'h05] = m_work;
               else bad = 1'b1;
            end
            mie_pkg::MIE_OP_MOVE_WORK_TO_FILE: m_file[a] = m_work;
            mie_pkg::MIE_OP_LOAD_IMM_TO_WORK: m_work = im;
            default: ;
         endcase
      end
      chk8(working_register, m_work, "work");
      chk1(zero_flag, m_zero, "zero");
      chk11(pc, m_pc, "pc");
      chk11(stack_top, m_stack, "stack");
      chk8(port_dir_a, m_dir[0], "dir a");
      chk8(port_dir_b, m_dir[1], "dir b");
      chk8(port_dir_c, m_dir[2], "dir c");
      chk1(discarded, disc, "discarded");
      chk1(retired, !disc, "retired");
      chk1(bad_operand, bad, "bad operand");
      chk1(instr_ready, !trap, "ready");
      if (trap) begin
         @(negedge sys_clk);
         chk1(instr_ready, 1'b1, "ready after trap");
      end
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      #50us;
      fail("timeout");
      tally_and_finish();
   end

   initial begin
      int i;
      mie_pkg::mie_op_t op;
      logic [5:0] a;
      void'($urandom(40));
      m_work = mie_pkg::MIE_WORK_RESET;
      m_pc = mie_pkg::MIE_PC_RESET;
      m_stack = 11'h000;
      m_zero = 1'b0;
      m_skip = 1'b0;
      for (i = 0; i < 3; i++) m_dir[i] = mie_pkg::MIE_DIR_RESET;
      repeat (16) @(negedge sys_clk);
      chk1(instr_ready, 1'b0, "reset ready");
      chk11(pc, m_pc, "reset pc");
      chk8(port_dir_b, m_dir[1], "reset dir");
      resetn = 1'b1;
      // File memory is not reset, so fill it first
      for (i = 0; i < 64; i++) begin
         do_op(mie_pkg::MIE_OP_LOAD_IMM_TO_WORK, 6'h00, 1'b0, 8'($urandom));
         do_op(mie_pkg::MIE_OP_MOVE_WORK_TO_FILE, 6'(i), 1'b0, 8'h00);
      end
      do_op(mie_pkg::MIE_OP_LOAD_IMM_TO_WORK, 6'h00, 1'b0, 8'hff);
      do_op(mie_pkg::MIE_OP_MOVE_WORK_TO_FILE, 6'h0a, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_MOVE_WORK_TO_FILE, 6'h3f, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_INC_SKIP_ZERO, 6'h0a, 1'b1, 8'h00);
      do_op(mie_pkg::MIE_OP_LOAD_IMM_TO_WORK, 6'h00, 1'b0, 8'h55);
      do_op(mie_pkg::MIE_OP_LOAD_IMM_TO_WORK, 6'h00, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_OR_WORK_WITH_FILE, 6'h0a, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_INC_SKIP_ZERO, 6'h3f, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_SOFT_TRAP, 6'h00, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_SOFT_TRAP, 6'h00, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_SOFT_TRAP, 6'h00, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_OR_IMM_INTO_WORK, 6'h00, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_OR_IMM_INTO_WORK, 6'h00, 1'b0, 8'h80);
      for (i = 5; i < 8; i++) begin
         do_op(mie_pkg::MIE_OP_LOAD_IMM_TO_WORK, 6'h00, 1'b0, 8'(i * 17));
         do_op(mie_pkg::MIE_OP_PORT_DIRECTION_LOAD, 6'(i), 1'b0, 8'h00);
      end
      for (i = 0; i < 400; i++) begin
         op = mie_pkg::mie_op_t'($urandom_range(7, 0));
         a = 6'($urandom_range(63, 0));
         if (op == mie_pkg::MIE_OP_PORT_DIRECTION_LOAD)
            a = 6'($urandom_range(7, 5));
         do_op(op, a, 1'($urandom), 8'($urandom));
      end
      // Refused operands still advance the program counter
      do_op(mie_pkg::MIE_OP_PORT_DIRECTION_LOAD, 6'h08, 1'b0, 8'h00);
      do_op(mie_pkg::MIE_OP_PORT_DIRECTION_LOAD, 6'h04, 1'b0, 8'h00);
      tally_and_finish();
   end
endmodule

// *** hw/mie_alu.sv ***
// Result path of the execution core: operand selection, result, zero
// flag and write-back steering. Purely combinational, same clock as caller.
`timescale 1ns/1ps
module mie_alu (
   input wire mie_pkg::mie_op_t op,
   input wire logic dest_file,
   input wire logic [7:0] work,
   input wire logic [7:0] file_val,
   input wire logic [7:0] imm,
   output logic [7:0] result,
   output logic zero,
   output logic write_work,
   output logic write_file,
   output logic write_zero,
   output logic skip
);
   wire is_inc = (op == mie_pkg::MIE_OP_INC_SKIP_ZERO);
   wire is_or_file = (op == mie_pkg::MIE_OP_OR_WORK_WITH_FILE);
   wire is_or_imm = (op == mie_pkg::MIE_OP_OR_IMM_INTO_WORK);
   wire is_move = (op == mie_pkg::MIE_OP_MOVE_WORK_TO_FILE);
   wire is_load = (op == mie_pkg::MIE_OP_LOAD_IMM_TO_WORK);
   wire [7:0] inc_val = 8'(file_val + 8'h01);

   // ------------------------------------------------------------
   // Result and steering
   // ------------------------------------------------------------
   assign result = is_inc ? inc_val :
      is_or_file ? (work | file_val) :
      is_or_imm ? (work | imm) :
      is_load ? imm :
      work;
   assign zero = (result == 8'h00);
   assign write_zero = is_or_file | is_or_imm;
   assign write_work = ((is_inc | is_or_file) & ~dest_file)
      | is_or_imm | is_load;
   assign write_file = ((is_inc | is_or_file) & dest_file) | is_move;
   assign skip = is_inc & (inc_val == 8'h00);
endmodule

// *** hw/mie_core.sv ***
// Execution core for a subset of an 8-bit instruction set.
// Assumes a fetch stage on sys_clk that holds instr_* until instr_ready.
//
// Summary of operation
// - Increment-and-skip adds one to file register; d picks destination.
// - Zero increment result discards the prefetched instruction as a NOP.
// - Trap pushes PC plus one, then loads vector 002h into PC.
// - Trap takes two cycles on 28-pin, three on 18-pin variants.
// - Register-OR ORs working and file register, updates zero flag.
// - Register-OR result goes to working register if d=0, else file.
// - Immediate-OR ORs 8-bit immediate into working register, sets zero.
// - Direction load copies working register to direction register 5-7.
// - Move-to-file copies working register into file register, no flags.
// - Load-immediate puts the immediate into working register, no flags.
// - Load-immediate completes in one cycle.
`timescale 1ns/1ps
module mie_core #(
   parameter bit PIN28 = 1'b1,
   parameter int STACK_DEPTH = mie_pkg::MIE_STACK_DEPTH
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire mie_pkg::mie_op_t instr_op,
   input wire logic [5:0] instr_addr,
   input wire logic instr_dest,
   input wire logic [7:0] instr_imm,
   output logic instr_ready,
   output logic [7:0] working_register,
   output logic zero_flag,
   output logic [10:0] pc,
   output logic [10:0] stack_top,
   output logic [7:0] port_dir_a,
   output logic [7:0] port_dir_b,
   output logic [7:0] port_dir_c,
   output logic retired,
   output logic discarded,
   output logic bad_operand
);
   localparam int TRAP_N = PIN28 ? mie_pkg::MIE_TRAP_CYCLES_28PIN
      : mie_pkg::MIE_TRAP_CYCLES_18PIN;
   localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

   initial begin
      if (STACK_DEPTH < 2) begin
         $error("STACK_DEPTH must be at least 2");
      end
   end

   typedef enum logic [1:0] {
      MIE_ST_RUN = 2'b01,
      MIE_ST_TRAP = 2'b10
   } mie_state_t;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic [7:0] file_mem [mie_pkg::MIE_FILE_WORDS];
   logic [10:0] stack_mem [STACK_DEPTH];
   logic [SP_W-1:0] sp;
   logic skip_pending;
   logic [1:0] wait_cnt;
   mie_state_t state;
   logic [7:0] dir_reg [mie_pkg::MIE_DIR_COUNT];

   wire [7:0] file_val = file_mem[instr_addr];
   wire take = instr_valid & instr_ready;
   wire exec = take & ~skip_pending;
   // A discarded slot still advances the PC, exactly like a NOP
   wire discard = take & skip_pending;
   wire is_trap = (instr_op == mie_pkg::MIE_OP_SOFT_TRAP);
   wire is_dir = (instr_op == mie_pkg::MIE_OP_PORT_DIRECTION_LOAD);
   wire [5:0] dir_off = 6'(instr_addr - mie_pkg::MIE_DIR_FIRST);
   wire dir_ok = (instr_addr >= mie_pkg::MIE_DIR_FIRST) &&
      (dir_off < 6'(mie_pkg::MIE_DIR_COUNT));
   wire [10:0] pc_plus1 = 11'(pc + 11'h001);
   wire [SP_W-1:0] next_sp = (sp == SP_W'(STACK_DEPTH - 1)) ? '0
      : SP_W'(sp + 1'b1);

   logic [7:0] result;
   logic zero;
   logic write_work;
   logic write_file;
   logic write_zero;
   logic skip;

   mie_alu u_alu (
      .op(instr_op),
      .dest_file(instr_dest),
      .work(working_register),
      .file_val(file_val),
      .imm(instr_imm),
      .result(result),
      .zero(zero),
      .write_work(write_work),
      .write_file(write_file),
      .write_zero(write_zero),
      .skip(skip)
   );

   // ------------------------------------------------------------
   // Trap sequencing
   // ------------------------------------------------------------
   // Trap holds off the fetch stage for its extra cycles
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= MIE_ST_RUN;
         wait_cnt <= 2'h0;
         instr_ready <= 1'b0;
      end else begin
         case (state)
            MIE_ST_RUN: begin
               instr_ready <= 1'b1;
               if (exec && is_trap) begin
                  state <= MIE_ST_TRAP;
                  wait_cnt <= 2'(TRAP_N - 2);
                  instr_ready <= 1'b0;
               end
            end
            MIE_ST_TRAP: begin
               if (wait_cnt == 2'h0) begin
                  state <= MIE_ST_RUN;
                  instr_ready <= 1'b1;
               end else begin
                  wait_cnt <= 2'(wait_cnt - 2'h1);
               end
            end
            default: begin
               state <= MIE_ST_RUN;
               instr_ready <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Architectural state
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         working_register <= mie_pkg::MIE_WORK_RESET;
         zero_flag <= 1'b0;
         pc <= mie_pkg::MIE_PC_RESET;
         stack_top <= mie_pkg::MIE_PC_RESET;
         sp <= '0;
         skip_pending <= 1'b0;
         retired <= 1'b0;
         discarded <= 1'b0;
         bad_operand <= 1'b0;
      end else begin
         retired <= exec;
         discarded <= discard;
         bad_operand <= exec & is_dir & ~dir_ok;
         if (discard) begin
            skip_pending <= 1'b0;
            pc <= pc_plus1;
         end
         if (exec) begin
            skip_pending <= skip;
            if (write_work) begin
               working_register <= result;
            end
            if (write_zero) begin
               zero_flag <= zero;
            end
            if (is_trap) begin
               pc <= mie_pkg::MIE_TRAP_VECTOR;
               stack_top <= pc_plus1;
               sp <= next_sp;
            end else begin
               pc <= pc_plus1;
            end
         end
      end
   end

   // Stack is circular: overflow silently overwrites the oldest entry
   always_ff @(posedge sys_clk) begin
      if (exec && is_trap) begin
         stack_mem[next_sp] <= pc_plus1;
      end
      if (exec && write_file) begin
         file_mem[instr_addr] <= result;
      end
   end

   // ------------------------------------------------------------
   // Port direction registers
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < mie_pkg::MIE_DIR_COUNT; gi++) begin : g_dir
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               dir_reg[gi] <= mie_pkg::MIE_DIR_RESET;
            end else if (exec && is_dir && dir_ok &&
               dir_off == 6'(gi)) begin
               dir_reg[gi] <= working_register;
            end
         end
      end
   endgenerate
   assign port_dir_a = dir_reg[0];
   assign port_dir_b = dir_reg[1];
   assign port_dir_c = dir_reg[2];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_inc_work_dest: assert property (@(posedge sys_clk) disable iff (!rst_n)
      exec && instr_op == mie_pkg::MIE_OP_INC_SKIP_ZERO && !instr_dest
      |=> working_register == 8'($past(file_val) + 8'h01) &&
      $stable(zero_flag))
      else $error("increment result not in working register");
   a_skip_discards: assert property (@(posedge sys_clk) disable iff (!rst_n)
      exec && instr_op == mie_pkg::MIE_OP_INC_SKIP_ZERO &&
      file_val == 8'hff ##1 take |-> discard ##1
      (discarded && $stable(working_register)))
      else $error("prefetched instruction not discarded");
   a_trap_vector_push: assert property (@(posedge sys_clk)
      disable iff (!rst_n) exec && is_trap
      |=> pc == mie_pkg::MIE_TRAP_VECTOR &&
      stack_top == 11'($past(pc) + 11'h001) && stack_mem[sp] == stack_top
      && $stable(zero_flag))
      else $error("trap vector or return address wrong");
   a_trap_cycle_count: assert property (@(posedge sys_clk)
      disable iff (!rst_n) exec && is_trap
      |=> !instr_ready ##(TRAP_N - 1) instr_ready)
      else $error("trap length wrong");
   a_or_file_work: assert property (@(posedge sys_clk) disable iff (!rst_n)
      exec && instr_op == mie_pkg::MIE_OP_OR_WORK_WITH_FILE && !instr_dest
      |=> working_register == ($past(working_register) | $past(file_val))
      && zero_flag == (working_register == 8'h00))
      else $error("register OR wrong");
   a_or_imm_work: assert property (@(posedge sys_clk) disable iff (!rst_n)
      exec && instr_op == mie_pkg::MIE_OP_OR_IMM_INTO_WORK
      |=> working_register == ($past(working_register) | $past(instr_imm))
      && zero_flag == (working_register == 8'h00))
      else $error("immediate OR wrong");
   a_dir_load_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
      exec && is_dir && instr_addr == mie_pkg::MIE_DIR_FIRST
      |=> port_dir_a == $past(working_register) && $stable(zero_flag)
      && !bad_operand)
      else $error("direction load wrong");
   a_move_no_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      exec && instr_op == mie_pkg::MIE_OP_MOVE_WORK_TO_FILE
      |=> $stable(zero_flag) && $stable(working_register) &&
      file_mem[$past(instr_addr)] == working_register)
      else $error("move to file wrong");
   a_load_imm_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
      exec && instr_op == mie_pkg::MIE_OP_LOAD_IMM_TO_WORK
      |=> working_register == $past(instr_imm) && $stable(zero_flag)
      && instr_ready)
      else $error("load immediate wrong");
endmodule

// *** inc/mie_pkg.sv ***
// Constants and operation codes shared by the instruction execution core.
// Assumes the fetch stage presents operations already split into fields.
package mie_pkg;

   // ------------------------------------------------------------
   // Operation codes presented by the fetch stage
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MIE_OP_NOP = 3'h0,
      MIE_OP_INC_SKIP_ZERO = 3'h1,
      MIE_OP_SOFT_TRAP = 3'h2,
      MIE_OP_OR_WORK_WITH_FILE = 3'h3,
      MIE_OP_OR_IMM_INTO_WORK = 3'h4,
      MIE_OP_PORT_DIRECTION_LOAD = 3'h5,
      MIE_OP_MOVE_WORK_TO_FILE = 3'h6,
      MIE_OP_LOAD_IMM_TO_WORK = 3'h7
   } mie_op_t;

   // ------------------------------------------------------------
   // Widths, vectors and reset values
   // ------------------------------------------------------------
   localparam int MIE_DATA_W = 8;
   localparam int MIE_ADDR_W = 6;
   localparam int MIE_PC_W = 11;
   localparam int MIE_FILE_WORDS = 64;
   localparam logic [10:0] MIE_TRAP_VECTOR = 11'h002;
   localparam logic [10:0] MIE_PC_RESET = 11'h000;
   localparam logic [7:0] MIE_WORK_RESET = 8'h00;
   localparam logic [7:0] MIE_DIR_RESET = 8'hff;
   localparam logic [5:0] MIE_DIR_FIRST = 6'h05;
   localparam int MIE_DIR_COUNT = 3;
   localparam int MIE_TRAP_CYCLES_28PIN = 2;
   localparam int MIE_TRAP_CYCLES_18PIN = 3;
   localparam int MIE_STACK_DEPTH = 4;

endpackage
